// ==== src/iehp_host_port.sv ====
// isa/eisa host bus port: slave i/o decode, lane steering, dma burst path
// assumes all bus pins are synchronous to sys_clk; strobes derived externally
`timescale 1ns/1ps

module iehp_host_port #(
	parameter int unsigned DW = iehp_pkg::DATA_W
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// configuration
	input  wire logic                 eisa_mode,
	input  wire logic [11:0]          decode_base,
	// slave address and control
	input  wire logic [15:1]          bus_address,
	input  wire logic                 address_enable,
	input  wire logic                 address_strobe_n,
	input  wire logic                 byte_lane_enable0_n,
	input  wire logic                 byte_lane_enable1_n,
	input  wire logic                 byte_lane_enable2_n,
	input  wire logic                 byte_lane_enable3_n,
	input  wire logic                 read_strobe_n,
	input  wire logic                 write_strobe_n,
	output logic                      local_device_decode_n,
	// data bus, input and output per pin, output enable per byte lane
	input  wire logic [DW-1:0]        data_in,
	output logic      [DW-1:0]        data_out,
	output logic      [3:0]           data_oe_n,
	// dma burst pins
	input  wire logic                 burst_transfer_clock,
	input  wire logic                 dma_ack_n,
	input  wire logic                 dma_cycle_indicator_n,
	input  wire logic                 dma_direction,
	input  wire logic                 ready_return_n,
	output logic                      dma_stall,
	// interrupt
	input  wire logic                 irq_pending,
	input  wire logic                 irq_new,
	output logic                      interrupt_output,
	// register side toward the controller
	output logic      [15:1]          reg_addr,
	output logic      [3:0]           reg_be,
	output logic      [DW-1:0]        reg_wdata,
	output logic                      reg_wr,
	output logic                      reg_rd,
	input  wire logic [DW-1:0]        reg_rdata,
	// dma words from the bus, to the controller
	output logic      [DW-1:0]        dma_wr_data,
	output logic                      dma_wr_valid,
	input  wire logic                 dma_wr_ready,
	// dma words from the controller, to the bus
	input  wire logic [DW-1:0]        dma_src_data,
	input  wire logic                 dma_src_valid,
	output logic                      dma_src_ready
);

	////////////////////////////////////////////////////////////////////////////
	// address, enable and byte enable latches
	logic [15:1]   addr_hold_ff;
	logic          aen_hold_ff;
	logic [3:0]    be_hold_ff;
	logic [3:0]    be_pins_n;
	logic [15:1]   addr_eff;
	logic          aen_eff;
	logic [3:0]    be_eff_n;
	logic [3:0]    lane_sel;
	logic          dev_hit;

	assign be_pins_n = {byte_lane_enable3_n, byte_lane_enable2_n,
	                    byte_lane_enable1_n, byte_lane_enable0_n};

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			addr_hold_ff <= '0;
			aen_hold_ff  <= 1'b1;
			be_hold_ff   <= iehp_pkg::BE_NONE_N;
		end else if (!address_strobe_n) begin
			addr_hold_ff <= bus_address;
			aen_hold_ff  <= address_enable;
			be_hold_ff   <= be_pins_n;
		end
	end

	// transparent while the strobe is low, held once it rises
	assign addr_eff = address_strobe_n ? addr_hold_ff : bus_address;
	assign aen_eff  = address_strobe_n ? aen_hold_ff : address_enable;
	assign be_eff_n = address_strobe_n ? be_hold_ff : be_pins_n;

	// 16-bit mode has no upper word
	assign lane_sel = eisa_mode ? ~be_eff_n : {2'b00, ~be_eff_n[1:0]};

	assign dev_hit = (addr_eff[iehp_pkg::DEC_ADDR_MSB:iehp_pkg::DEC_ADDR_LSB] == decode_base)
	                 && !aen_eff;
	assign local_device_decode_n = !dev_hit;

	////////////////////////////////////////////////////////////////////////////
	// slave i/o strobes
	logic          rd_prev_ff;
	logic          wr_prev_ff;
	logic [2:0]    rd_cnt_ff;
	logic          rd_busy_ff;
	logic [DW-1:0] io_dout_ff;
	logic [DW-1:0] wdata_ff;
	logic          reg_wr_ff;
	logic          reg_rd_ff;
	logic [15:1]   reg_addr_ff;
	logic [3:0]    reg_be_ff;
	logic          dma_sel;
	logic          rd_fall;
	logic          wr_rise;
	logic          rd_capture;
	logic          io_rd_active;

	assign dma_sel      = !dma_ack_n;
	assign rd_fall      = rd_prev_ff && !read_strobe_n && dev_hit && !dma_sel;
	assign wr_rise      = !wr_prev_ff && write_strobe_n && dev_hit && !dma_sel;
	assign rd_capture   = rd_busy_ff && (rd_cnt_ff == iehp_pkg::READ_LAT_CYC);
	assign io_rd_active = !read_strobe_n && dev_hit && !dma_sel;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_prev_ff <= 1'b1;
			wr_prev_ff <= 1'b1;
		end else begin
			rd_prev_ff <= read_strobe_n;
			wr_prev_ff <= write_strobe_n;
		end
	end

	// read data is ready two cycles after the leading edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_busy_ff <= 1'b0;
			rd_cnt_ff  <= '0;
		end else if (rd_fall) begin
			rd_busy_ff <= 1'b1;
			rd_cnt_ff  <= 3'h1;
		end else if (rd_capture) begin
			rd_busy_ff <= 1'b0;
		end else if (rd_busy_ff) begin
			rd_cnt_ff  <= rd_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			io_dout_ff <= '0;
		end else if (rd_capture) begin
			io_dout_ff <= reg_rdata;
		end
	end

	// write data follows the bus while the strobe is low, last value kept
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wdata_ff <= '0;
		end else if (!write_strobe_n) begin
			wdata_ff <= data_in;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_wr_ff   <= 1'b0;
			reg_rd_ff   <= 1'b0;
			reg_addr_ff <= '0;
			reg_be_ff   <= '0;
		end else begin
			reg_wr_ff <= wr_rise;
			reg_rd_ff <= rd_fall;
			if (wr_rise || rd_fall) begin
				reg_addr_ff <= addr_eff;
				reg_be_ff   <= lane_sel;
			end
		end
	end

	assign reg_wr    = reg_wr_ff;
	assign reg_rd    = reg_rd_ff;
	assign reg_addr  = reg_addr_ff;
	assign reg_be    = reg_be_ff;
	assign reg_wdata = wdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// dma burst beats
	logic          bclk_prev_ff;
	logic          bclk_rise;
	logic          burst_on;
	logic          beat_ok;
	logic          beat_in;
	logic          beat_out;
	logic          buf_full;
	logic          dma_out_mode;
	logic [DW-1:0] dma_dout_ff;
	logic          dout_valid_ff;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bclk_prev_ff <= 1'b0;
		end else begin
			bclk_prev_ff <= burst_transfer_clock;
		end
	end

	assign bclk_rise    = burst_transfer_clock && !bclk_prev_ff;
	assign burst_on     = dma_sel && !dma_cycle_indicator_n;
	assign dma_out_mode = dma_sel && dma_direction;
	// whole words only; the master keeps bursts aligned
	assign beat_ok      = bclk_rise && burst_on && !ready_return_n;
	assign beat_in      = beat_ok && !dma_direction && !buf_full;
	assign beat_out     = beat_ok && dma_direction && dout_valid_ff;
	assign dma_stall    = dma_direction ? !dout_valid_ff : buf_full;

	// outgoing word preloaded so each burst clock finds one ready
	assign dma_src_ready = dma_src_valid && (!dout_valid_ff || beat_out);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dout_valid_ff <= 1'b0;
			dma_dout_ff   <= '0;
		end else if (dma_src_ready) begin
			dout_valid_ff <= 1'b1;
			dma_dout_ff   <= dma_src_data;
		end else if (beat_out) begin
			dout_valid_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// two-entry buffer for incoming dma words
	logic [DW-1:0] buf_mem [0:1];
	logic          wr_ptr_ff;
	logic          rd_ptr_ff;
	logic [1:0]    cnt_ff;
	logic          buf_pop;
	logic [1:0]    nxt_cnt;

	assign buf_full     = (cnt_ff == iehp_pkg::BUF_DEPTH);
	assign dma_wr_valid = (cnt_ff != 2'h0);
	assign dma_wr_data  = buf_mem[rd_ptr_ff];
	assign buf_pop      = dma_wr_valid && dma_wr_ready;
	assign nxt_cnt      = cnt_ff + {1'b0, beat_in} - {1'b0, buf_pop};

	always_ff @(posedge sys_clk) begin
		if (beat_in) begin
			buf_mem[wr_ptr_ff] <= data_in;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			cnt_ff    <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff ^ beat_in;
			rd_ptr_ff <= rd_ptr_ff ^ buf_pop;
			cnt_ff    <= nxt_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data bus drive
	assign data_out  = dma_out_mode ? dma_dout_ff : io_dout_ff;
	assign data_oe_n = dma_out_mode ? 4'h0 :
	                   io_rd_active ? ~lane_sel : iehp_pkg::BE_NONE_N;

	////////////////////////////////////////////////////////////////////////////
	// interrupt output
	logic int_ff;
	logic nxt_int;

	// one low cycle before a fresh condition so the host sees a new edge
	assign nxt_int = irq_pending && !(irq_new && int_ff);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			int_ff <= 1'b0;
		end else begin
			int_ff <= nxt_int;
		end
	end

	assign interrupt_output = int_ff;
endmodule : iehp_host_port

// ==== src/iehp_pkg.sv ====
// constants for the isa/eisa host bus port
// assumes one 125 MHz system clock and bus pins already synchronous to it
package iehp_pkg;
	// timing
	localparam int unsigned CLK_PERIOD_PS   = 8000;
	localparam int unsigned ACCESS_MAX_NS   = 180;
	localparam int unsigned ACCESS_MAX_CYC  = (ACCESS_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [2:0]  READ_LAT_CYC    = 3'h2;

	// address field of the device decode
	localparam int unsigned DEC_ADDR_MSB    = 15;
	localparam int unsigned DEC_ADDR_LSB    = 4;
	localparam logic [11:0] DEC_BASE_RST    = 12'h030;

	// buffer shape
	localparam int unsigned DATA_W          = 32;
	localparam logic [1:0]  BUF_DEPTH       = 2'h2;

	// byte lanes
	localparam int unsigned LANES           = 4;
	localparam logic [3:0]  BE_NONE_N       = 4'hf;
endpackage : iehp_pkg

// ==== verif/iehp_checker.sv ====
// checker: decode, strobe pulses, lanes, waits and interrupt of the host port
// assumes decode_base is held steady by the surroundings
`timescale 1ns/1ps
module iehp_checker (
	input wire logic        sys_clk, reset, eisa_mode, address_enable, address_strobe_n,
	input wire logic        byte_lane_enable0_n, byte_lane_enable1_n, read_strobe_n,
	input wire logic        write_strobe_n, local_device_decode_n, dma_ack_n, dma_direction,
	input wire logic        ready_return_n, irq_pending, irq_new, interrupt_output,
	input wire logic        reg_rd, reg_wr, dma_wr_valid,
	input wire logic [11:0] decode_base,
	input wire logic [15:1] bus_address,
	input wire logic [3:0]  data_oe_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire       hit  = bus_address[15:4] == decode_base && !address_enable;
	wire       sel  = !local_device_decode_n && dma_ack_n;
	wire [1:0] be_n = {byte_lane_enable1_n, byte_lane_enable0_n};
	property p_dec; !address_strobe_n && !$past(address_strobe_n) && $stable(bus_address)
		&& $stable(address_enable) |-> local_device_decode_n == !hit; endproperty
	a_dec: assert property (p_dec) else $error("decode wrong");
	property p_rd; $fell(read_strobe_n) && sel |=> reg_rd ##1 !reg_rd; endproperty
	a_rd: assert property (p_rd) else $error("read pulse wrong");
	property p_wr; $rose(write_strobe_n) && sel |=> reg_wr ##1 !reg_wr; endproperty
	a_wr: assert property (p_wr) else $error("write pulse wrong");
	property p_isa; !eisa_mode |-> data_oe_n[3:2] == 2'h3; endproperty
	a_isa: assert property (p_isa) else $error("upper lanes driven");
	property p_idle; read_strobe_n && dma_ack_n |-> data_oe_n == 4'hf; endproperty
	a_idle: assert property (p_idle) else $error("lanes driven idle");
	property p_lane; !eisa_mode && !read_strobe_n && sel && $stable(be_n)
		|-> data_oe_n[1:0] == be_n; endproperty
	a_lane: assert property (p_lane) else $error("lane select wrong");
	property p_hold; address_strobe_n [*3] |-> $stable(local_device_decode_n); endproperty
	a_hold: assert property (p_hold) else $error("latched decode moved");
	property p_wait; !dma_direction && ready_return_n && $past(ready_return_n)
		&& !dma_wr_valid |=> !dma_wr_valid; endproperty
	a_wait: assert property (p_wait) else $error("beat taken in wait");
	property p_irq; $rose(irq_pending) && !irq_new |=> interrupt_output; endproperty
	a_irq: assert property (p_irq) else $error("interrupt late");
	property p_dip; irq_new && interrupt_output && irq_pending
		|-> ##[1:2] !interrupt_output ##1 interrupt_output; endproperty
	a_dip: assert property (p_dip) else $error("no fresh edge");
endmodule : iehp_checker

bind iehp_host_port iehp_checker iehp_checker_inst (.sys_clk, .reset, .eisa_mode,
	.address_enable, .address_strobe_n, .byte_lane_enable0_n, .byte_lane_enable1_n,
	.read_strobe_n, .write_strobe_n, .local_device_decode_n, .dma_ack_n, .dma_direction,
	.ready_return_n, .irq_pending, .irq_new, .interrupt_output, .reg_rd, .reg_wr,
	.dma_wr_valid, .decode_base, .bus_address, .data_oe_n);

// ==== verif/iehp_host_model.sv ====
// host bus controller side of dma bursts: burst clock, acknowledge, waits
// assumes run and slow come from the bench in the sys_clk domain
`timescale 1ns/1ps
module iehp_host_model (
	// control
	input  wire logic sys_clk,
	input  wire logic run,
	input  wire logic slow,
	// bus side
	output logic      burst_transfer_clock,
	output logic      dma_ack_n,
	output logic      dma_cycle_indicator_n,
	output logic      ready_return_n
);
	logic [2:0] cnt_ff = 3'h0;
	// burst clock stands still outside bursts
	always_ff @(posedge sys_clk) begin
		if (run)
			cnt_ff <= cnt_ff + 3'h1;
	end
	assign burst_transfer_clock  = cnt_ff[1];
	assign dma_ack_n             = !run;
	assign dma_cycle_indicator_n = !run;
	assign ready_return_n        = !run || (slow && cnt_ff[2]);
endmodule : iehp_host_model

// ==== verif/iehp_host_port_bench.sv ====
// bench for the host port: slave access, lanes, latching, dma in, interrupt, dma out
// assumes the host model paces bursts; controller side driven here
`timescale 1ns/1ps
module iehp_host_port_bench;
	logic        sys_clk = 1'b0, reset = 1'b1, eisa_mode = 1'b0, address_enable = 1'b1;
	logic        address_strobe_n = 1'b0, read_strobe_n = 1'b1, write_strobe_n = 1'b1;
	logic        irq_pending = 1'b0, irq_new = 1'b0, dma_wr_ready = 1'b0, run = 1'b0;
	logic        slow = 1'b0, local_device_decode_n, dma_stall, interrupt_output, reg_wr;
	logic        reg_rd, dma_wr_valid, burst_transfer_clock, dma_ack_n, ready_return_n;
	logic        dma_cycle_indicator_n, dma_src_ready, dma_direction = 1'b0, dma_src_valid = 1'b0;
	logic [31:0] dma_src_data = 32'h0;
	logic [3:0]  be_n = 4'hf, data_oe_n, reg_be;
	logic [11:0] decode_base = 12'h030;
	logic [15:1] bus_address = 15'h0, reg_addr;
	logic [31:0] data_in = 32'h0, reg_rdata = 32'h0, data_out, reg_wdata, dma_wr_data;
	int          err_total = 0, check_count = 0, rd_total = 0, src_total = 0;

	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) rd_total <= rd_total + reg_rd;
	always @(posedge sys_clk) src_total <= src_total + dma_src_ready;

	iehp_host_model iehp_host_model_inst (.sys_clk, .run, .slow, .burst_transfer_clock,
		.dma_ack_n, .dma_cycle_indicator_n, .ready_return_n);
	iehp_host_port iehp_host_port_inst (.sys_clk, .reset, .eisa_mode, .decode_base,
		.bus_address, .address_enable, .address_strobe_n, .byte_lane_enable0_n(be_n[0]),
		.byte_lane_enable1_n(be_n[1]), .byte_lane_enable2_n(be_n[2]),
		.byte_lane_enable3_n(be_n[3]), .read_strobe_n, .write_strobe_n,
		.local_device_decode_n, .data_in, .data_out, .data_oe_n, .burst_transfer_clock,
		.dma_ack_n, .dma_cycle_indicator_n, .dma_direction, .ready_return_n,
		.dma_stall, .irq_pending, .irq_new, .interrupt_output, .reg_addr, .reg_be,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dma_wr_data, .dma_wr_valid,
		.dma_wr_ready, .dma_src_data, .dma_src_valid, .dma_src_ready);

	////////////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task isa_read;
		bus_address <= {decode_base, 3'h0};
		address_enable <= 1'b0;
		be_n <= 4'he;
		reg_rdata <= 32'hc3c3_a55a;
		cyc(3);
		chk("decode", local_device_decode_n, 1'b0);
		read_strobe_n <= 1'b0;
		cyc(5);
		chk("oe", data_oe_n, 4'he);
		chk("lane0", data_out[7:0], 8'h5a);
		chk("addr", reg_addr, {decode_base, 3'h0});
		read_strobe_n <= 1'b1;
		cyc(2);
	endtask : isa_read
	task isa_write;
		be_n <= 4'hd;
		data_in <= 32'h0000_5600;
		write_strobe_n <= 1'b0;
		cyc(3);
		write_strobe_n <= 1'b1;
		cyc(3);
		chk("be", reg_be, 4'h2);
		chk("wdata", reg_wdata[15:8], 8'h56);
	endtask : isa_write
	task refused;
		address_enable <= 1'b1;
		cyc(3);
		read_strobe_n <= 1'b0;
		cyc(4);
		chk("nodec", local_device_decode_n, 1'b1);
		chk("nodrive", data_oe_n, 4'hf);
		read_strobe_n <= 1'b1;
		cyc(2);
		chk("reads", rd_total, 1);
	endtask : refused
	task eisa_hold;
		eisa_mode <= 1'b1;
		address_enable <= 1'b0;
		bus_address <= {decode_base, 3'h0};
		be_n <= 4'h0;
		cyc(2);
		address_strobe_n <= 1'b1;
		cyc(1);
		bus_address <= 15'h0;
		address_enable <= 1'b1;
		be_n <= 4'hf;
		read_strobe_n <= 1'b0;
		cyc(5);
		chk("held", local_device_decode_n, 1'b0);
		chk("oe32", data_oe_n, 4'h0);
		chk("be32", reg_be, 4'hf);
		read_strobe_n <= 1'b1;
		address_strobe_n <= 1'b0;
		eisa_mode <= 1'b0;
		cyc(2);
	endtask : eisa_hold
	task dma_in;
		data_in <= 32'h0bad_f00d;
		run <= 1'b1;
		cyc(11);
		chk("full", dma_stall, 1'b1);
		chk("word", dma_wr_data, 32'h0bad_f00d);
		run <= 1'b0;
		dma_wr_ready <= 1'b1;
		cyc(4);
		chk("empty", dma_wr_valid, 1'b0);
		dma_wr_ready <= 1'b0;
		slow <= 1'b1;
		run <= 1'b1;
		cyc(12);
		chk("onebeat", dma_stall, 1'b0);
		chk("oneword", dma_wr_valid, 1'b1);
		cyc(12);
		chk("waited", dma_stall, 1'b1);
		run <= 1'b0;
		dma_wr_ready <= 1'b1;
	endtask : dma_in
	task irq;
		int lows;
		lows = 0;
		irq_pending <= 1'b1;
		cyc(3);
		chk("irq", interrupt_output, 1'b1);
		irq_new <= 1'b1;
		cyc(1);
		irq_new <= 1'b0;
		repeat (4) begin
			cyc(1);
			lows += !interrupt_output;
		end
		chk("dip", lows, 1);
		irq_pending <= 1'b0;
	endtask : irq
	task dma_out;
		eisa_mode <= 1'b1;
		slow <= 1'b0;
		dma_direction <= 1'b1;
		dma_src_data <= 32'h5aa5_0ff0;
		dma_src_valid <= 1'b1;
		cyc(2);
		chk("preload", dma_stall, 1'b0);
		run <= 1'b1;
		cyc(12);
		chk("oe_dma", data_oe_n, 4'h0);
		chk("dma_word", data_out, 32'h5aa5_0ff0);
		chk("beats", src_total, 3);
		run <= 1'b0;
		dma_src_valid <= 1'b0;
		dma_direction <= 1'b0;
		eisa_mode <= 1'b0;
		cyc(2);
	endtask : dma_out

	initial begin
		cyc(16);
		reset <= 1'b0;
		cyc(2);
		isa_read;
		isa_write;
		refused;
		eisa_hold;
		dma_in;
		irq;
		dma_out;
		wrap_up;
	end
	initial begin
		cyc(3000);
		err_total++;
		wrap_up;
	end
endmodule : iehp_host_port_bench
